// ==== timer_one_consts.vh ====
// Purpose: Constants for the gated sixteen-bit timer with Wishbone access.
// Assumes: 8-bit register data in the low bits of a 32-bit Wishbone word.
// Notes:   Byte addresses are four times the register index.
`ifndef TIMER_ONE_CONSTS_VH
`define TIMER_ONE_CONSTS_VH

// ****************************************************************
// Register indices and byte addresses
// ****************************************************************
`define IDX_COUNT_LOW        8'h0E
`define IDX_COUNT_HIGH       8'h0F
`define IDX_CONTROL          8'h10
`define IDX_STATUS           8'h11
`define IDX_ANALOG_SELECT    8'h12
`define ADDR_W               10
`define ADDR_COUNT_LOW       10'h038
`define ADDR_COUNT_HIGH      10'h03C
`define ADDR_CONTROL         10'h040
`define ADDR_STATUS          10'h044
`define ADDR_ANALOG_SELECT   10'h048

// ****************************************************************
// Register fields, limits and reset values
// ****************************************************************
`define CTL_RUN              0
`define CTL_CLK_SRC          1
`define CTL_SYNC_DIS         2
`define CTL_OSC_EN           3
`define CTL_PS_LO            4
`define CTL_PS_HI            5
`define CTL_GATE_EN          6
`define CTL_GATE_INV         7
`define CONTROL_RESET        8'h00
`define ANALOG_RESET         2'h3
`define ANA_CLK_PIN          0
`define ANA_GATE_PIN         1
`define STAT_OVF             0
`define STAT_OSC_ON          1
`define COUNT_RESET          16'h0000
`define COUNT_MAX            16'hFFFF
`define PS_RESET             3'h0
`define INST_PHASE_RESET     2'h0
`define INST_PHASE_LAST      2'h3

`endif

// ==== timer_edge_sync.v ====
// Purpose: Two-flop synchroniser with rising and falling edge outputs.
// Assumes: Input is asynchronous to clk_i.
// Notes:   The first flop feeds only the second flop.
`timescale 1ns/1ps
module timer_edge_sync
(
  input  wire clk_i,    // Sampling clock
  input  wire reset_i,  // Asynchronous reset, active high
  input  wire async_i,  // Asynchronous level
  output wire level_o,  // Synchronised level
  output wire rise_o,   // One-cycle pulse on rising edge
  output wire fall_o    // One-cycle pulse on falling edge
);
  reg meta;
  reg stable;
  reg last;

  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      meta   <= 1'b0;
      stable <= 1'b0;
      last   <= 1'b0;
    end
    else
    begin
      meta   <= async_i;
      stable <= meta;
      last   <= stable;
    end
  end

  assign level_o = stable;
  assign rise_o  = stable & ~last;
  assign fall_o  = ~stable & last;
endmodule // timer_edge_sync

// ==== timer_one.v ====
// Purpose: Gated sixteen-bit timer/counter with prescaler and Wishbone registers.
// Assumes: ref_clk_i is 50 MHz; the instruction cycle is four clocks.
// Notes:   The unsynchronised path is modelled by taking the synchroniser's edge
//          one stage ahead of the synchronised path, so reads remain coherent.
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
`include "timer_one_consts.vh"
module timer_one
(
  input  wire        ref_clk_i,        // System clock, 50 MHz
  input  wire        reset_i,          // Asynchronous reset, active high
  input  wire        wb_cyc_i,         // Wishbone cycle
  input  wire        wb_stb_i,         // Wishbone strobe
  input  wire        wb_we_i,          // Wishbone write enable
  input  wire [9:0]  wb_adr_i,         // Wishbone byte address
  input  wire [3:0]  wb_sel_i,         // Wishbone byte selects
  input  wire [31:0] wb_dat_i,         // Wishbone write data
  output reg  [31:0] wb_dat_o,         // Wishbone read data
  output reg         wb_ack_o,         // Wishbone acknowledge
  output reg         wb_err_o,         // Wishbone error on unmapped address
  input  wire        external_clock_pin_i, // External count clock pin
  input  wire        gate_input_pin_i, // Gate pin
  input  wire        comparator_b_output_i, // Comparator gate source
  input  wire        gate_source_select_i, // 1 selects comparator as gate
  input  wire        internal_oscillator_i, // System runs on internal oscillator
  input  wire        clock_output_pin_en_i, // Clock output pin is enabled
  input  wire        sleep_i,          // Processor is sleeping
  output reg         overflow_flag_o,  // Sticky overflow flag
  output wire        wake_o,           // Wake request on overflow
  output wire        osc_power_o       // Crystal oscillator power enable
);
  // ****************************************************************
  // Registers
  // ****************************************************************
  reg  [7:0]  timer_one_control;
  reg  [1:0]  analog_pin_select;
  reg  [15:0] count;
  reg  [2:0]  prescale;
  reg  [1:0]  inst_phase;
  reg         armed;
  reg  [7:0]  next_rdata;
  reg         next_mapped;

  wire        clk_lvl;
  wire        clk_rise;
  wire        clk_fall;
  wire        gate_lvl;
  wire        cmp_lvl;
  reg         raw_rise;
  reg         raw_last;

  // analogue pins read as zero.
  // The mask acts after the synchronisers, so no logic sits ahead of the first flop.
  wire clk_pin_dig  = ~analog_pin_select[`ANA_CLK_PIN];
  wire gate_pin_dig = ~analog_pin_select[`ANA_GATE_PIN];

  // synchronised path for the external clock.
  timer_edge_sync u_clk_sync
  (
    .clk_i   (ref_clk_i),
    .reset_i (reset_i),
    .async_i (external_clock_pin_i),
    .level_o (clk_lvl),
    .rise_o  (clk_rise),
    .fall_o  (clk_fall)
  );

  timer_edge_sync u_gate_sync
  (
    .clk_i   (ref_clk_i),
    .reset_i (reset_i),
    .async_i (gate_input_pin_i),
    .level_o (gate_lvl),
    .rise_o  (),
    .fall_o  ()
  );

  timer_edge_sync u_cmp_sync
  (
    .clk_i   (ref_clk_i),
    .reset_i (reset_i),
    .async_i (comparator_b_output_i),
    .level_o (cmp_lvl),
    .rise_o  (),
    .fall_o  ()
  );

  // unsynchronised path takes the edge a stage earlier, with no phase alignment.
  always @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      raw_last <= 1'b0;
      raw_rise <= 1'b0;
    end
    else
    begin
      raw_last <= clk_lvl;
      raw_rise <= clk_rise;
    end
  end

  // ****************************************************************
  // Count clock selection
  // ****************************************************************
  wire run      = timer_one_control[`CTL_RUN];
  wire ext_src  = timer_one_control[`CTL_CLK_SRC];
  wire sync_dis = timer_one_control[`CTL_SYNC_DIS];
  wire [1:0] ps_code = {timer_one_control[`CTL_PS_HI], timer_one_control[`CTL_PS_LO]};
  wire inst_tick = (inst_phase == `INST_PHASE_LAST);

  // oscillator only powered from internal oscillator without clock out.
  assign osc_power_o = timer_one_control[`CTL_OSC_EN] & internal_oscillator_i
                       & ~clock_output_pin_en_i;

  // invert selected gate; gate only counts when enabled.
  wire gate_sel    = gate_source_select_i ? cmp_lvl : (gate_lvl & gate_pin_dig);
  wire gate_active = gate_sel ^ timer_one_control[`CTL_GATE_INV];
  wire gate_ok     = ~timer_one_control[`CTL_GATE_EN] | gate_active;

  // internal source uses instruction clock; external edges.
  wire ext_edge = clk_pin_dig & (sync_dis ? clk_rise : raw_rise);
  // sleep stops synchronous counting; asynchronous mode keeps running.
  wire src_evt  = ext_src ? (ext_edge & armed & (sync_dis | ~sleep_i))
                          : (inst_tick & ~sleep_i);
  // run bit qualifies every count event.
  wire evt      = src_evt & run & gate_ok;

  function ps_done;
    input [1:0] code;
    input [2:0] cnt;
    begin
      case (code)
        2'h0:    ps_done = 1'b1;
        2'h1:    ps_done = (cnt[0] == 1'b1);
        2'h2:    ps_done = (cnt[1:0] == 2'h3);
        default: ps_done = (cnt == 3'h7);
      endcase
    end
  endfunction

  // ****************************************************************
  // Wishbone decode
  // ****************************************************************
  wire req   = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  // Writes land at the edge where the master samples ack, while it still holds the request.
  wire wr    = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
  wire wr_lo = wr & (wb_adr_i == `ADDR_COUNT_LOW);
  wire wr_hi = wr & (wb_adr_i == `ADDR_COUNT_HIGH);
  wire inc   = evt & ps_done(ps_code, prescale);
  wire ovf   = inc & (count == `COUNT_MAX);

  always @*
  begin
    next_rdata  = 8'h00;
    next_mapped = 1'b1;
    case (wb_adr_i)
      // reads come from the system-clock count register, always stable.
      `ADDR_COUNT_LOW:     next_rdata = count[7:0];
      `ADDR_COUNT_HIGH:    next_rdata = count[15:8];
      `ADDR_CONTROL:       next_rdata = timer_one_control;
      `ADDR_STATUS:        next_rdata = {6'h00, osc_power_o, overflow_flag_o};
      `ADDR_ANALOG_SELECT: next_rdata = {6'h00, analog_pin_select};
      default:             next_mapped = 1'b0;
    endcase
  end

  always @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      wb_ack_o          <= 1'b0;
      wb_err_o          <= 1'b0;
      wb_dat_o          <= 32'h00000000;
      timer_one_control <= `CONTROL_RESET;
      analog_pin_select <= `ANALOG_RESET;
    end
    else
    begin
      wb_ack_o <= req & next_mapped;
      wb_err_o <= req & ~next_mapped;
      if (req)
        wb_dat_o <= {24'h000000, next_rdata};
      if (wr && wb_adr_i == `ADDR_CONTROL)
        timer_one_control <= wb_dat_i[7:0];
      if (wr && wb_adr_i == `ADDR_ANALOG_SELECT)
        analog_pin_select <= wb_dat_i[1:0];
    end
  end

  // ****************************************************************
  // Counter, prescaler and overflow
  // ****************************************************************
  always @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      count           <= `COUNT_RESET;
      prescale        <= `PS_RESET;
      inst_phase      <= `INST_PHASE_RESET;
      armed           <= 1'b0;
      overflow_flag_o <= 1'b0;
    end
    else
    begin
      inst_phase <= inst_phase + 2'h1;
      // a falling edge arms counting once the counter is started on the external clock.
      if (!run || !ext_src)
        armed <= 1'b0;
      else if (clk_pin_dig && (clk_fall || (raw_last && !clk_lvl)))
        armed <= 1'b1;
      // any count byte write clears the prescaler.
      if (wr_lo || wr_hi)
        prescale <= `PS_RESET;
      else if (inc)
        prescale <= `PS_RESET;
      else if (evt)
        prescale <= prescale + 3'h1;
      // a colliding write takes priority over the increment.
      if (wr_lo)
        count[7:0] <= wb_dat_i[7:0];
      else if (inc)
        count[7:0] <= count[7:0] + 8'h01;
      if (wr_hi)
        count[15:8] <= wb_dat_i[7:0];
      else if (inc && !wr_lo)
        count[15:8] <= count[15:8] + {7'h00, (count[7:0] == 8'hFF)};
      // overflow sets the flag; set wins over a software clear.
      if (ovf)
        overflow_flag_o <= 1'b1;
      else if (wr && wb_adr_i == `ADDR_STATUS && !wb_dat_i[`STAT_OVF])
        overflow_flag_o <= 1'b0;
    end
  end

  assign wake_o = overflow_flag_o & sleep_i;
endmodule // timer_one

// ==== timer_one_sva.sv ====
// Purpose: Concurrent checks on the timer's bus answers, wake and oscillator outputs.
// Assumes: One clock domain; reset asynchronous, active high.
// Notes:   Bound to every timer_one instance after the module.
`timescale 1ns/1ps
`include "timer_one_consts.vh"
module timer_one_sva
(
  input wire logic        ref_clk_i,             // Clock
  input wire logic        reset_i,               // Reset
  input wire logic        wb_cyc_i,              // Cycle
  input wire logic        wb_stb_i,              // Strobe
  input wire logic        wb_we_i,               // Write
  input wire logic [9:0]  wb_adr_i,              // Address
  input wire logic [31:0] wb_dat_o,              // Read data
  input wire logic        wb_ack_o,              // Acknowledge
  input wire logic        wb_err_o,              // Error
  input wire logic        overflow_flag_o,       // Overflow flag
  input wire logic        wake_o,                // Wake request
  input wire logic        osc_power_o,           // Oscillator power
  input wire logic        sleep_i,               // Sleep
  input wire logic        internal_oscillator_i, // Internal oscillator
  input wire logic        clock_output_pin_en_i  // Clock output on
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  wire req = wb_cyc_i & wb_stb_i;
  wire hit = wb_adr_i inside {`ADDR_COUNT_LOW, `ADDR_COUNT_HIGH, `ADDR_CONTROL, `ADDR_STATUS,
                              `ADDR_ANALOG_SELECT};
  a_answer_pulse: assert property ((wb_ack_o || wb_err_o) |=> !(wb_ack_o || wb_err_o))
    else $error("answer held past one cycle");
  a_answer_next: assert property (req && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o)
    else $error("request not answered in the next cycle");
  a_ack_mapped: assert property (wb_ack_o |-> $past(hit) && !wb_err_o)
    else $error("ack for an unmapped address");
  a_err_unmapped: assert property (wb_err_o |-> !$past(hit))
    else $error("error for a mapped address");
  a_read_byte: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read data not zero");
  a_wake_cause: assert property (wake_o == (overflow_flag_o && sleep_i))
    else $error("wake does not follow flag and sleep");
  a_osc_config: assert property (osc_power_o |-> internal_oscillator_i && !clock_output_pin_en_i)
    else $error("oscillator powered in wrong clock setup");
  a_flag_sticky: assert property ($past(overflow_flag_o) && !$past(req && wb_we_i)
    |-> overflow_flag_o)
    else $error("overflow flag dropped without a write");
  c_err: cover property (wb_err_o);
  c_wake: cover property (wake_o);
  c_osc: cover property (osc_power_o);
endmodule // timer_one_sva
bind timer_one timer_one_sva i_sva (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
  .overflow_flag_o(overflow_flag_o), .wake_o(wake_o), .osc_power_o(osc_power_o),
  .sleep_i(sleep_i), .internal_oscillator_i(internal_oscillator_i),
  .clock_output_pin_en_i(clock_output_pin_en_i));

// ==== ext_clock_model.sv ====
// Purpose: External count clock source driving the timer's clock pin.
// Assumes: Pulses are slow against the 50 MHz system clock.
// Notes:   Idles high, so every burst opens with a falling edge.
`timescale 1ns/1ps
module ext_clock_model
#(
  parameter int HALF_NS = 110
)
(
  output logic pin_o // External count clock
);
  initial pin_o = 1'h1;
  task automatic burst(input int n);
    repeat (n)
    begin
      #HALF_NS pin_o = 1'h0;
      #HALF_NS pin_o = 1'h1;
    end
  endtask
endmodule // ext_clock_model

// ==== testbench.sv ====
// Purpose: Self-checking bench for the gated sixteen-bit timer.
// Assumes: Count bytes are written only while the counter is stopped.
// Notes:   Timer-mode counts are checked within one tick of the ideal.
`timescale 1ns/1ps
`include "timer_one_consts.vh"
module testbench;
  logic        clk = 1'h0, reset_i = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, e;
  logic        gate = 1'h0, cmp = 1'h0, gss = 1'h0, ios = 1'h0, clko = 1'h0, slp = 1'h0;
  logic [9:0]  adr = 10'h000;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0, rd, s = 32'h6084AC3D;
  logic [11:0] gt [6] = '{12'h841, 12'h041, 12'h0C1, 12'h6C1, 12'h941, 12'h001};
  logic [7:0]  c;
  wire  [31:0] dat_o;
  wire         ack, err, flag, wake, oscp, pin;
  int          num_errors = 0, checks_done = 0, cycles = 0, n, m;
  always #10 clk = ~clk;
  timer_one i_timer_one (.ref_clk_i(clk), .reset_i(reset_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .wb_err_o(err), .external_clock_pin_i(pin), .gate_input_pin_i(gate),
    .comparator_b_output_i(cmp), .gate_source_select_i(gss), .internal_oscillator_i(ios),
    .clock_output_pin_en_i(clko), .sleep_i(slp), .overflow_flag_o(flag), .wake_o(wake),
    .osc_power_o(oscp));
  ext_clock_model i_ext_clock_model (.pin_o(pin));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Ticks in a 256-cycle run plus the bus overhead around it.
  function automatic int ticks(input logic [1:0] ps);
    return 266 / (4 << ps);
  endfunction
  function automatic logic near(input logic [7:0] got, input int exp);
    return int'(got) >= exp - 1 && int'(got) <= exp + 1;
  endfunction
  // A gated-off counter must not move; an ungated one runs freely.
  function automatic logic runs(input logic [11:0] t);
    return !t[6] || (t[7] ^ (t[9] ? t[10] : t[11] & !t[8]));
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat <= {24'h000000, d};
    do @(posedge clk); while (!(ack | err));
    rd = dat_o;
    e = err;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask
  // Stops the counter before touching the count bytes, so no write meets an increment.
  task automatic run(input logic [7:0] ctl, input int k, input logic ext);
    wb(1'h1, `ADDR_CONTROL, 8'h00);
    wb(1'h1, `ADDR_COUNT_LOW, 8'h00);
    wb(1'h1, `ADDR_COUNT_HIGH, 8'h00);
    wb(1'h1, `ADDR_CONTROL, ctl);
    if (ext)
      i_ext_clock_model.burst(k);
    else
      repeat (k) @(posedge clk);
    repeat (8) @(posedge clk);
    wb(1'h1, `ADDR_CONTROL, ctl & 8'hFE);
    wb(1'h0, `ADDR_COUNT_LOW, 8'h00);
    c = rd[7:0];
    repeat (16) @(posedge clk);
    wb(1'h0, `ADDR_COUNT_LOW, 8'h00);
    chk(rd, {24'h000000, c});
  endtask
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      num_errors++;
      print_verdict;
    end
  end
  initial
  begin
    repeat (12) @(posedge clk);
    reset_i <= 1'h0;
    wb(1'h0, `ADDR_CONTROL, 8'h00);
    chk(rd, 32'h0);
    repeat (6)
    begin
      s = lfsr(s);
      wb(1'h1, `ADDR_CONTROL, s[7:0]);
      wb(1'h0, `ADDR_CONTROL, 8'h00);
      chk(rd, {24'h000000, s[7:0]});
    end
    wb(1'h0, 10'h3FC, 8'h00);
    chk(e, 1'h1);
    wb(1'h1, `ADDR_CONTROL, 8'h08);
    for (n = 0; n < 4; n++)
    begin
      ios <= n[0];
      clko <= n[1];
      repeat (2) @(posedge clk);
      chk(oscp, n[0] & !n[1]);
    end
    for (n = 0; n < 4; n++)
    begin
      run({2'h0, n[1:0], 1'h0, n[0], 2'h1}, 256, 1'h0);
      chk(near(c, ticks(n[1:0])), 1'h1);
    end
    for (n = 0; n < 6; n++)
    begin
      {gate, cmp, gss} <= gt[n][11:9];
      wb(1'h1, `ADDR_ANALOG_SELECT, {6'h00, gt[n][8], 1'h0});
      run(gt[n][7:0], 256, 1'h0);
      chk(near(c, runs(gt[n]) ? ticks(2'h0) : 0), 1'h1);
    end
    for (n = 0; n < 4; n++)
    begin
      s = lfsr(s);
      m = 1 + s[4:0];
      run({2'h0, s[9:8], 1'h0, s[10], 2'h3}, m, 1'h1);
      chk(c, m >> s[9:8]);
    end
    wb(1'h1, `ADDR_ANALOG_SELECT, 8'h01);
    run(8'h07, 6, 1'h1);
    chk(c, 8'h00);
    wb(1'h1, `ADDR_ANALOG_SELECT, 8'h00);
    slp <= 1'h1;
    run(8'h03, 5, 1'h1);
    chk(c, 8'h00);
    run(8'h07, 5, 1'h1);
    chk(c, 8'h05);
    wb(1'h1, `ADDR_COUNT_LOW, 8'hFE);
    wb(1'h1, `ADDR_COUNT_HIGH, 8'hFF);
    wb(1'h1, `ADDR_CONTROL, 8'h07);
    i_ext_clock_model.burst(3);
    repeat (8) @(posedge clk);
    chk({flag, wake}, 2'h3);
    slp <= 1'h0;
    wb(1'h0, `ADDR_COUNT_LOW, 8'h00);
    chk(rd, 32'h1);
    chk({flag, wake}, 2'h2);
    wb(1'h1, `ADDR_STATUS, 8'h00);
    wb(1'h0, `ADDR_STATUS, 8'h00);
    chk(rd[0], 1'h0);
    print_verdict;
  end
endmodule // testbench
